// file: design/dap_core.sv
// Notes on behaviour
// - four link pins mirror remote or feed back
// - nibble 5 forward output, 3 back input
// - link pin levels readable; local output possible
// - nibble 1 low, 9 high, 3 input
// - pins five to eight register driven; 7,8 carry audio when off
// - register pin mode overrides shared audio pad
// - local and control channel both reach registers
// - register pins never cross the link
// - four data lines, word select splits channels
// - no audio in backward compatible mode
// - older partner: A at 24-bit, AB at 18-bit
// - data island transport taken from serializer
// - audio config off: frame transport, line A only
// - four lines only island with newer partner
// - two-line mode written explicitly per device
// - repeater may regenerate from audio input pins
// - master clock off with PLL off; default x2
// - divider codes for 16-bit words
// - divider codes for 24-bit words
//
`timescale 1ns/100ps
`include "dap_defines.svh"

module dap_core
#(
   parameter int CNT_W = 8
)
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // local register port
   input  wire dap_pkg::dap_reg_req_s loc_req,
   output dap_pkg::dap_reg_rsp_s      loc_rsp,
   // control channel register port
   input  wire dap_pkg::dap_reg_req_s rem_req,
   output dap_pkg::dap_reg_rsp_s      rem_rsp,
   // link side pin state
   input  wire logic [3:0]            fwd_pin_state,
   output logic [3:0]                 back_pin_level,
   // audio sources
   input  wire dap_pkg::dap_audio_s   audio_island,
   input  wire dap_pkg::dap_audio_s   audio_frame,
   input  wire dap_pkg::dap_audio_s   audio_rpt_in,
   // mode straps from the link and pins
   input  wire logic                  island_mode,
   input  wire logic                  backward_compat_mode,
   input  wire logic                  partner_surround,
   input  wire logic                  video_18bit,
   // link pin pads 0..3 (2,3 carry audio data c,d)
   input  wire logic [3:0]            link_pad_in,
   output logic [3:0]                 link_pad_out,
   output logic [3:0]                 link_pad_oe,
   // register pin pads 5..8 (7,8 carry word select, bit clock)
   input  wire logic [3:0]            reg_pad_in,
   output logic [3:0]                 reg_pad_out,
   output logic [3:0]                 reg_pad_oe,
   // dedicated audio outputs
   output logic                       audio_data_a,
   output logic                       audio_data_b,
   output logic                       master_clock
);
   import dap_pkg::*;

   // ****************************************
   // input synchronisers
   // ****************************************
   localparam int SW = 34;

   logic [SW-1:0] sync1_ff;
   logic [SW-1:0] sync2_ff;
   logic [3:0]    fwd_s;
   logic [3:0]    link_in_s;
   logic [3:0]    reg_in_s;
   dap_audio_s    island_s;
   dap_audio_s    frame_s;
   dap_audio_s    rpt_s;
   logic          island_s_mode;
   logic          backward_compat_mode_s;
   logic          surround_s;
   logic          v18_s;

   // every pin and link level crosses two flops before use
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= {fwd_pin_state, link_pad_in, reg_pad_in, audio_island, audio_frame, audio_rpt_in,
                      island_mode, backward_compat_mode, partner_surround, video_18bit};
         sync2_ff <= sync1_ff;
      end
   end

   assign {fwd_s, link_in_s, reg_in_s, island_s, frame_s, rpt_s,
           island_s_mode, backward_compat_mode_s, surround_s, v18_s} = sync2_ff;

   // ****************************************
   // register file
   // ****************************************
   logic [7:0]   pin_cfg_ff [5];
   logic [7:0]   pll_ctl_ff;
   logic [7:0]   mclk_sel_ff;
   logic         loc_ack_ff;
   logic         rem_ack_ff;
   logic [7:0]   loc_rdata_ff;
   logic [7:0]   rem_rdata_ff;
   logic         loc_take;
   logic         rem_take;
   dap_reg_req_s req;
   logic [7:0]   levels_low;
   logic [7:0]   levels_high;
   logic [3:0]   link_level;
   logic [3:0]   reg_level;

   // local wins a same-cycle clash; the control channel simply waits
   assign loc_take = loc_req.valid & ~loc_ack_ff;
   assign rem_take = rem_req.valid & ~rem_ack_ff & ~loc_take;
   assign req      = loc_take ? loc_req : rem_req;

   assign levels_low  = {reg_level[2:0], 1'b0, link_level};
   assign levels_high = {7'b000_0000, reg_level[3]};

   // read decode shared by both ports; unmapped reads give zero
   function automatic logic [7:0] read_mux(input logic [7:0] addr);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         `DAP_OFS_LINK_PIN0:   v = pin_cfg_ff[0];
         `DAP_OFS_LINK_PIN1_2: v = pin_cfg_ff[1];
         `DAP_OFS_LINK_PIN3:   v = pin_cfg_ff[2];
         `DAP_OFS_REG_PIN5_6:  v = pin_cfg_ff[3];
         `DAP_OFS_REG_PIN7_8:  v = pin_cfg_ff[4];
         `DAP_OFS_AUDIO_PLL:   v = pll_ctl_ff;
         `DAP_OFS_MCLK_SEL:    v = mclk_sel_ff;
         `DAP_OFS_LEVELS_LOW:  v = levels_low;
         `DAP_OFS_LEVELS_HIGH: v = levels_high;
         default:              v = 8'h00;
      endcase
      return v;
   endfunction

   // writes from whichever port was taken; read-only and unmapped ignored
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < 5; k++)
            pin_cfg_ff[k] <= `DAP_RST_PIN_CFG;
         pll_ctl_ff  <= `DAP_RST_AUDIO_PLL;
         mclk_sel_ff <= `DAP_RST_MCLK_SEL;
      end
      else if ((loc_take | rem_take) && req.write)
      begin
         case (req.addr)
            `DAP_OFS_LINK_PIN0:   pin_cfg_ff[0] <= req.wdata;
            `DAP_OFS_LINK_PIN1_2: pin_cfg_ff[1] <= req.wdata;
            `DAP_OFS_LINK_PIN3:   pin_cfg_ff[2] <= req.wdata;
            `DAP_OFS_REG_PIN5_6:  pin_cfg_ff[3] <= req.wdata;
            `DAP_OFS_REG_PIN7_8:  pin_cfg_ff[4] <= req.wdata;
            `DAP_OFS_AUDIO_PLL:   pll_ctl_ff    <= req.wdata;
            `DAP_OFS_MCLK_SEL:    mclk_sel_ff   <= req.wdata;
            default:              pll_ctl_ff    <= pll_ctl_ff;
         endcase
      end
   end

   // answers come one cycle after the take and stand one cycle
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         loc_ack_ff   <= 1'b0;
         rem_ack_ff   <= 1'b0;
         loc_rdata_ff <= 8'h00;
         rem_rdata_ff <= 8'h00;
      end
      else
      begin
         loc_ack_ff   <= loc_take;
         rem_ack_ff   <= rem_take;
         loc_rdata_ff <= (loc_take && !req.write) ? read_mux(req.addr) : 8'h00;
         rem_rdata_ff <= (rem_take && !req.write) ? read_mux(req.addr) : 8'h00;
      end
   end

   assign loc_rsp = '{ack: loc_ack_ff, rdata: loc_rdata_ff};
   assign rem_rsp = '{ack: rem_ack_ff, rdata: rem_rdata_ff};

   // ****************************************
   // audio routing
   // ****************************************
   dap_audio_s src;
   logic       island_eff;
   logic [3:0] line_en;
   logic       audio_on;

   // software turning audio config off falls back to frame transport
   assign island_eff = island_s_mode & ~pll_ctl_ff[`DAP_AUD_CFG_OFF_BIT];
   assign audio_on   = ~backward_compat_mode_s;
   assign src        = pll_ctl_ff[`DAP_RPT_PINS_BIT] ? rpt_s :
                       (island_eff ? island_s : frame_s);

   // lines that may carry audio for this partner and transport
   always_comb
   begin
      if (!audio_on)
         line_en = 4'b0000;
      else if (!island_eff)
         line_en = 4'b0001;
      else if (surround_s && !pll_ctl_ff[`DAP_TWO_LINE_BIT])
         line_en = 4'b1111;
      else if (surround_s)
         line_en = 4'b0011;
      else
         line_en = v18_s ? 4'b0011 : 4'b0001;
   end

   // ****************************************
   // pin control
   // ****************************************
   logic [3:0] reg_nib [4];
   logic [3:0] link_out_ff;
   logic [3:0] link_oe_ff;
   logic [3:0] reg_out_ff;
   logic [3:0] reg_oe_ff;
   logic [3:0] back_ff;
   logic [3:0] shared_reg_audio;

   // forward mode only exists on link pins; on register pins it is off
   function automatic dap_pin_mode_e pin_mode(input logic [3:0] nib, input logic is_link);
      dap_pin_mode_e m;
      m = DAP_PM_OFF;
      case (nib)
         `DAP_NIB_FWD:      m = is_link ? DAP_PM_FWD : DAP_PM_OFF;
         `DAP_NIB_INPUT:    m = DAP_PM_IN;
         `DAP_NIB_OUT_LOW:  m = DAP_PM_LOW;
         `DAP_NIB_OUT_HIGH: m = DAP_PM_HIGH;
         default:           m = DAP_PM_OFF;
      endcase
      return m;
   endfunction

   assign reg_nib[0]         = pin_cfg_ff[3][3:0];
   assign reg_nib[1]         = pin_cfg_ff[3][7:4];
   assign reg_nib[2]         = pin_cfg_ff[4][3:0];
   assign reg_nib[3]         = pin_cfg_ff[4][7:4];
   assign shared_reg_audio   = {src.bclk, src.wsel, 2'b00};
   assign link_level         = link_in_s;
   assign reg_level          = reg_in_s;

   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_pin
         logic [3:0]    lnib;
         dap_pin_mode_e lmode;
         dap_pin_mode_e rmode;
         logic          laud;
         logic          raud;

         assign lnib  = (i == 0) ? pin_cfg_ff[0][3:0] : (i == 1) ? pin_cfg_ff[1][3:0] :
                        (i == 2) ? pin_cfg_ff[1][7:4] : pin_cfg_ff[2][3:0];
         assign lmode = pin_mode(lnib, 1'b1);
         assign rmode = pin_mode(reg_nib[i], 1'b0);
         // pads 2,3 double as audio data c,d; pads 7,8 as word select, bit clock
         assign laud  = (i >= 2) && line_en[i];
         assign raud  = (i >= 2) && audio_on;

         // link pins: mirror the remote side, drive locally, or float as input
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               link_out_ff[i] <= 1'b0;
               link_oe_ff[i]  <= 1'b0;
               back_ff[i]     <= 1'b0;
            end
            else
            begin
               back_ff[i] <= (lmode == DAP_PM_IN) ? link_in_s[i] : 1'b0;
               case (lmode)
                  DAP_PM_FWD:  begin link_out_ff[i] <= fwd_s[i]; link_oe_ff[i] <= 1'b1; end
                  DAP_PM_LOW:  begin link_out_ff[i] <= 1'b0;     link_oe_ff[i] <= 1'b1; end
                  DAP_PM_HIGH: begin link_out_ff[i] <= 1'b1;     link_oe_ff[i] <= 1'b1; end
                  DAP_PM_IN:   begin link_out_ff[i] <= 1'b0;     link_oe_ff[i] <= 1'b0; end
                  default:
                  begin
                     link_out_ff[i] <= laud & src.data[i];
                     link_oe_ff[i]  <= laud;
                  end
               endcase
            end
         end

         // register pins: register mode beats the shared audio function
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               reg_out_ff[i] <= 1'b0;
               reg_oe_ff[i]  <= 1'b0;
            end
            else
            begin
               case (rmode)
                  DAP_PM_LOW:  begin reg_out_ff[i] <= 1'b0; reg_oe_ff[i] <= 1'b1; end
                  DAP_PM_HIGH: begin reg_out_ff[i] <= 1'b1; reg_oe_ff[i] <= 1'b1; end
                  DAP_PM_IN:   begin reg_out_ff[i] <= 1'b0; reg_oe_ff[i] <= 1'b0; end
                  default:
                  begin
                     reg_out_ff[i] <= raud & shared_reg_audio[i];
                     reg_oe_ff[i]  <= raud;
                  end
               endcase
            end
         end
      end
   endgenerate

   assign link_pad_out   = link_out_ff;
   assign link_pad_oe    = link_oe_ff;
   assign reg_pad_out    = reg_out_ff;
   assign reg_pad_oe     = reg_oe_ff;
   assign back_pin_level = back_ff;

   // ****************************************
   // dedicated audio lines
   // ****************************************
   logic da_ff;
   logic db_ff;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         da_ff <= 1'b0;
         db_ff <= 1'b0;
      end
      else
      begin
         da_ff <= line_en[0] & src.data[0];
         db_ff <= line_en[1] & src.data[1];
      end
   end

   assign audio_data_a = da_ff;
   assign audio_data_b = db_ff;

   // ****************************************
   // master clock
   // ****************************************
   logic [CNT_W-1:0] bclk_period;
   logic [2:0]       div_code;
   logic [2:0]       base;
   logic [1:0]       ratio;
   logic             mclk_en;

   // the divider code is relative to a base that grows with bit clock rate
   assign base = (bclk_period > CNT_W'(`DAP_BAND0_CYC)) ? 3'd0 :
                 (bclk_period > CNT_W'(`DAP_BAND1_CYC)) ? 3'd1 :
                 (bclk_period > CNT_W'(`DAP_BAND2_CYC)) ? 3'd2 : 3'd3;
   assign div_code = mclk_sel_ff[`DAP_DIV_MSB:`DAP_DIV_LSB];
   assign ratio = !mclk_sel_ff[`DAP_DIV_OVR_BIT] ? 2'd1 :
                  (div_code <= base)            ? 2'd0 :
                  ((div_code - base) >= 3'd2)   ? 2'd2 : 2'(div_code - base);
   // PLL off means no master clock; the PLL would not lock below 1 MHz anyway
   assign mclk_en = audio_on & ~pll_ctl_ff[`DAP_PLL_OFF_BIT];

   dap_mclk_gen #(.CNT_W(CNT_W)) u_mclk
   (
      .clk    (clk),
      .rst_n  (rst_n),
      .bclk   (src.bclk),
      .enable (mclk_en),
      .ratio  (ratio),
      .mclk   (master_clock),
      .period (bclk_period)
   );

endmodule

// file: design/dap_defines.svh
`ifndef DAP_DEFINES_SVH
`define DAP_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define DAP_OFS_LINK_PIN0     8'h1D
`define DAP_OFS_LINK_PIN1_2   8'h1E
`define DAP_OFS_LINK_PIN3     8'h1F
`define DAP_OFS_REG_PIN5_6    8'h20
`define DAP_OFS_REG_PIN7_8    8'h21
`define DAP_OFS_AUDIO_PLL     8'h2B
`define DAP_OFS_MCLK_SEL      8'h3A
`define DAP_OFS_LEVELS_LOW    8'h6E
`define DAP_OFS_LEVELS_HIGH   8'h6F

// ****************************************
// reset values
// ****************************************
`define DAP_RST_PIN_CFG       8'h00
`define DAP_RST_AUDIO_PLL     8'h00
`define DAP_RST_MCLK_SEL      8'h00

// ****************************************
// pin nibble codes
// ****************************************
`define DAP_NIB_FWD           4'h5
`define DAP_NIB_INPUT         4'h3
`define DAP_NIB_OUT_LOW       4'h1
`define DAP_NIB_OUT_HIGH      4'h9

// ****************************************
// field positions
// ****************************************
`define DAP_PLL_OFF_BIT       7
`define DAP_AUD_CFG_OFF_BIT   0
`define DAP_TWO_LINE_BIT      1
`define DAP_RPT_PINS_BIT      2
`define DAP_DIV_OVR_BIT       7
`define DAP_DIV_MSB           6
`define DAP_DIV_LSB           4

// ****************************************
// timing: bit clock period bands for the divider base
// ****************************************
`define DAP_CLK_MHZ           100
`define DAP_BAND0_MHZ         2
`define DAP_BAND1_MHZ         4
`define DAP_BAND2_MHZ         8
`define DAP_BAND0_CYC         (`DAP_CLK_MHZ / `DAP_BAND0_MHZ)
`define DAP_BAND1_CYC         (`DAP_CLK_MHZ / `DAP_BAND1_MHZ)
`define DAP_BAND2_CYC         (`DAP_CLK_MHZ / `DAP_BAND2_MHZ)

`endif

// file: design/dap_mclk_gen.sv
`timescale 1ns/100ps

module dap_mclk_gen
#(
   parameter int CNT_W = 8
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // control
   input  wire logic             bclk,
   input  wire logic             enable,
   input  wire logic [1:0]       ratio,
   // results
   output logic                  mclk,
   output logic [CNT_W-1:0]      period
);
   logic             bclk_prev_ff;
   logic [CNT_W-1:0] per_cnt_ff;
   logic [CNT_W-1:0] period_ff;
   logic [CNT_W-1:0] tick_cnt_ff;
   logic             mclk_ff;
   logic             rise;
   logic [CNT_W-1:0] interval;

   assign rise   = bclk & ~bclk_prev_ff;
   assign mclk   = mclk_ff;
   assign period = period_ff;
   // half period of the wanted clock; never below one cycle
   assign interval = ((period_ff >> (ratio + 2'd1)) == '0) ? CNT_W'(1) : (period_ff >> (ratio + 2'd1));

   // measure the bit clock period in system cycles, saturating
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         bclk_prev_ff <= 1'b0;
         per_cnt_ff   <= '0;
         period_ff    <= '0;
      end
      else
      begin
         bclk_prev_ff <= bclk;
         if (rise)
         begin
            per_cnt_ff <= CNT_W'(1);
            period_ff  <= per_cnt_ff;
         end
         else if (per_cnt_ff != '1)
            per_cnt_ff <= per_cnt_ff + CNT_W'(1);
      end
   end

   // phase-aligned to each bit clock rise so drift never accumulates
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mclk_ff     <= 1'b0;
         tick_cnt_ff <= '0;
      end
      else if (!enable)
      begin
         mclk_ff     <= 1'b0;
         tick_cnt_ff <= '0;
      end
      else if (ratio == 2'd0)
         mclk_ff <= bclk;
      else if (rise)
      begin
         mclk_ff     <= 1'b1;
         tick_cnt_ff <= CNT_W'(1);
      end
      else if (tick_cnt_ff >= interval)
      begin
         mclk_ff     <= ~mclk_ff;
         tick_cnt_ff <= CNT_W'(1);
      end
      else
         tick_cnt_ff <= tick_cnt_ff + CNT_W'(1);
   end

endmodule

// file: design/dap_pkg.sv
package dap_pkg;

   // pad function decoded from a config nibble
   typedef enum logic [2:0]
   {
      DAP_PM_OFF  = 3'b000,
      DAP_PM_FWD  = 3'b001,
      DAP_PM_IN   = 3'b010,
      DAP_PM_LOW  = 3'b011,
      DAP_PM_HIGH = 3'b100
   } dap_pin_mode_e;

   // one serial audio bundle: bit clock, word select, four data lines
   typedef struct packed
   {
      logic       bclk;
      logic       wsel;
      logic [3:0] data;
   } dap_audio_s;

   // register request and answer
   typedef struct packed
   {
      logic       valid;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dap_reg_req_s;

   typedef struct packed
   {
      logic       ack;
      logic [7:0] rdata;
   } dap_reg_rsp_s;

endpackage

// file: tb/dap_codec_model.sv
`timescale 1ns/100ps
// ****
// serial audio receiver beside the pads
// ****
module dap_codec_model
(
   // serial audio from the device
   input  wire logic        bclk,
   input  wire logic        wsel,
   input  wire logic        data_a,
   // what the codec saw
   output logic [15:0]      rises,
   output logic [1:0]       last_bits
);
   // a codec samples on the bit clock rise, so count rises and keep the slot and data
   initial rises = 16'h0000;
   initial last_bits = 2'b00;
   always @(posedge bclk)
   begin
      rises <= rises + 16'h0001;
      last_bits <= {wsel, data_a};
   end
endmodule

// file: tb/dap_core_props.sv
`timescale 1ns/100ps
// ****
// port checker for the core
// ****
module dap_core_props
(
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // register ports
   input wire dap_pkg::dap_reg_req_s loc_req,
   input wire dap_pkg::dap_reg_rsp_s loc_rsp,
   input wire dap_pkg::dap_reg_req_s rem_req,
   input wire dap_pkg::dap_reg_rsp_s rem_rsp,
   // pins and audio
   input wire logic [3:0]            back_pin_level,
   input wire logic [3:0]            link_pad_oe,
   input wire logic                  backward_compat_mode,
   input wire logic                  audio_data_a,
   input wire logic                  audio_data_b,
   input wire logic                  master_clock
);
   import dap_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a taken local request answers on the very next edge
   chk_loc_ack_next: assert property (loc_req.valid && !loc_rsp.ack |=> loc_rsp.ack)
      else $error("local request not answered next cycle");
   chk_loc_ack_pulse: assert property (loc_rsp.ack |=> !loc_rsp.ack)
      else $error("local ack longer than one cycle");
   chk_rem_ack_pulse: assert property (rem_rsp.ack |=> !rem_rsp.ack)
      else $error("remote ack longer than one cycle");
   chk_rdata_idle: assert property (!loc_rsp.ack |-> loc_rsp.rdata == 8'h00)
      else $error("local read data outside ack");
   chk_one_port_ack: assert property (!(loc_rsp.ack && rem_rsp.ack))
      else $error("both ports answered together");
   chk_rem_ack_cause: assert property (rem_rsp.ack |-> $past(rem_req.valid))
      else $error("remote ack without request");
   // link pin 0 as an input reporting a level must not drive its pad
   chk_input_floats: assert property (back_pin_level[0] |-> !link_pad_oe[0])
      else $error("input pin drives its pad");
   // settled compat mode silences data lines a, b and the master clock
   chk_compat_silent: assert property (backward_compat_mode [*6] |-> !audio_data_a && !audio_data_b && !master_clock)
      else $error("audio active in compat mode");
endmodule

// file: tb/dap_core_test.sv
`timescale 1ns/100ps
module dap_core_test;
   import dap_pkg::*;
   // ****
   // stimulus and wiring
   // ****
   logic         clk = 0, rst_n = 0, isl = 1, bk = 0, sur = 1, v18 = 0, bclk = 0, da, db, mclk;
   dap_reg_req_s loc_req = '0, rem_req = '0;
   dap_reg_rsp_s loc_rsp, rem_rsp;
   logic [3:0]   fwd = 0, bpl, lin = 0, lout, loe, rin = 0, rout, roe, dat = 4'hF;
   logic [4:0]   bit_cnt = 0;
   logic [15:0]  rises;
   dap_audio_s   aud;
   dap_audio_s   rpt;
   logic [1:0]   lb;
   int           fails = 0, samples_checked = 0;
   assign aud = {bclk, bit_cnt[4], dat};
   // repeater source carries a different data pattern so its selection shows
   assign rpt = {bclk, bit_cnt[4], 4'h5};
   always #5 clk = ~clk;
   // 6.25 MHz bit clock, phase unrelated to clk, inside the legal band
   initial #3 forever #80 bclk = ~bclk;
   always @(negedge bclk) bit_cnt <= bit_cnt + 5'h01;
   dap_core dap_core_inst (.clk(clk), .rst_n(rst_n), .loc_req(loc_req), .loc_rsp(loc_rsp), .rem_req(rem_req),
      .rem_rsp(rem_rsp), .fwd_pin_state(fwd), .back_pin_level(bpl), .audio_island(aud), .audio_frame(aud),
      .audio_rpt_in(rpt), .island_mode(isl), .backward_compat_mode(bk), .partner_surround(sur),
      .video_18bit(v18), .link_pad_in(lin), .link_pad_out(lout), .link_pad_oe(loe), .reg_pad_in(rin),
      .reg_pad_out(rout), .reg_pad_oe(roe), .audio_data_a(da), .audio_data_b(db), .master_clock(mclk));
   dap_codec_model dap_codec_model_inst (.bclk(rout[3]), .wsel(rout[2]), .data_a(da), .rises(rises),
      .last_bits(lb));
   // ****
   // shared tasks
   // ****
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // request held until ack is sampled, then released
   task automatic acc(logic r, logic w, logic [7:0] a, logic [7:0] d, output logic [7:0] q);
      q = 8'hxx;
      @(posedge clk);
      if (r)
         rem_req <= '{1'b1, w, a, d};
      else
         loc_req <= '{1'b1, w, a, d};
      repeat (20)
      begin
         @(posedge clk);
         if ((r ? rem_rsp.ack : loc_rsp.ack) === 1'b1)
         begin
            q = r ? rem_rsp.rdata : loc_rsp.rdata;
            break;
         end
      end
      rem_req <= '0;
      loc_req <= '0;
      check("ack seen", 16'(!$isunknown(q)), 16'h0001);
   endtask
   task automatic wr(logic r, logic [7:0] a, logic [7:0] d);
      logic [7:0] q;
      acc(r, 1'b1, a, d, q);
      repeat (3) @(posedge clk);
   endtask
   task automatic rd(logic r, logic [7:0] a, logic [7:0] e, string what);
      logic [7:0] q;
      acc(r, 1'b0, a, 8'h00, q);
      check(what, q, e);
   endtask
   task automatic count(output int n);
      logic p;
      n = 0;
      p = mclk;
      repeat (160)
      begin
         @(posedge clk);
         n += int'(mclk && !p);
         p = mclk;
      end
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_regs;
      logic [7:0] ofs [7] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h2B, 8'h3A};
      foreach (ofs[i]) rd(0, ofs[i], 8'h00, "reset");
      rd(1, 8'h55, 8'h00, "unmapped");
      wr(1, 8'h6E, 8'hFF);
      rd(0, 8'h6E, 8'h00, "levels ro");
      wr(1, 8'h3A, 8'h35);
      rd(0, 8'h3A, 8'h35, "remote wr");
      wr(0, 8'h21, 8'h11);
      rd(1, 8'h21, 8'h11, "local wr");
      wr(0, 8'h3A, 8'h00);
   endtask
   task automatic t_pins;
      wr(0, 8'h1D, 8'h09);
      check("pin0 hi", {lout[0], loe[0]}, 2'b11);
      wr(0, 8'h1D, 8'h01);
      check("pin0 lo", {lout[0], loe[0]}, 2'b01);
      lin <= 4'h1;
      wr(0, 8'h1D, 8'h03);
      check("pin0 in", {bpl[0], loe[0]}, 2'b10);
      rd(0, 8'h6E, 8'h01, "pin0 level");
      lin <= 4'h0;
      wr(0, 8'h1D, 8'h00);
      fwd <= 4'h6;
      wr(1, 8'h1E, 8'h55);
      check("fwd", {lout[2:1], loe[2:1]}, 4'hF);
      fwd <= 4'h0;
      repeat (6) @(posedge clk);
      check("fwd lo", lout[2:1], 2'b00);
      wr(1, 8'h1E, 8'h00);
   endtask
   // pin 8 overrides the bit clock pad; link state must not leak in
   task automatic t_regpins;
      rin <= 4'h4;
      fwd <= 4'hF;
      wr(1, 8'h21, 8'h93);
      wr(0, 8'h20, 8'h19);
      check("regpins", {rout[3], rout[1:0], roe}, 7'h5B);
      rd(1, 8'h6E, 8'h80, "pin7 level");
      rd(0, 8'h6F, 8'h00, "pin8 level");
      fwd <= 4'h0;
      rin <= 4'h0;
      wr(0, 8'h20, 8'h00);
      wr(0, 8'h21, 8'h00);
   endtask
   // mode bits: island, surround, 18-bit, compat, two-line
   task automatic t_audio;
      logic [4:0] m [6] = '{5'h18, 5'h10, 5'h14, 5'h08, 5'h1A, 5'h19};
      logic [3:0] e [6] = '{4'hF, 4'h1, 4'h3, 4'h1, 4'h0, 4'h3};
      foreach (m[i])
      begin
         {isl, sur, v18, bk} <= m[i][4:1];
         wr(0, 8'h2B, {6'h00, m[i][0], 1'b0});
         repeat (8) @(posedge clk);
         check("lines", {lout[3:2], db, da}, e[i]);
      end
      {isl, sur, v18, bk} <= 4'hC;
      wr(0, 8'h2B, 8'h01);
      repeat (8) @(posedge clk);
      check("cfg off", {lout[3:2], db, da}, 4'h1);
      wr(0, 8'h2B, 8'h04);
      repeat (8) @(posedge clk);
      check("repeater", {lout[3:2], db, da}, 4'h5);
      wr(0, 8'h2B, 8'h00);
   endtask
   task automatic t_mclk;
      int n;
      logic [15:0] r0;
      r0 = rises;
      count(n);
      check("mclk x2", n >= 18 && n <= 22, 1'b1);
      check("codec clk", rises != r0, 1'b1);
      check("codec data", lb[0], 1'b1);
      wr(0, 8'h3A, 8'h80);
      for (int c = 2; c < 5; c++)
      begin
         wr(0, 8'h3A, {1'b1, 3'(c), 4'h0});
         repeat (64) @(posedge clk);
         count(n);
         check("mclk ratio", n >= (10 << (c - 2)) - 2 && n <= (10 << (c - 2)) + 2, 1'b1);
      end
      wr(0, 8'h2B, 8'h80);
      repeat (16) @(posedge clk);
      count(n);
      check("mclk off", 16'(n), 16'h0000);
      wr(0, 8'h2B, 8'h00);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****
   // main sequence and watchdog
   // ****
   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_pins;
      t_regpins;
      t_audio;
      t_mclk;
      report_and_stop;
   end
   initial
   begin
      #200us;
      fails++;
      report_and_stop;
   end
endmodule
bind dap_core dap_core_props dap_core_props_inst (.clk(clk), .rst_n(rst_n), .loc_req(loc_req), .loc_rsp(loc_rsp),
   .rem_req(rem_req), .rem_rsp(rem_rsp), .back_pin_level(back_pin_level), .link_pad_oe(link_pad_oe),
   .backward_compat_mode(backward_compat_mode), .audio_data_a(audio_data_a), .audio_data_b(audio_data_b),
   .master_clock(master_clock));
